// >>> rtl/psf_sample_fifo.sv
// Overview of operation
// - signed 24-bit sample in three bytes 28h-2Ah
// - buffer holds 32 complete sample words
// - enable bit and 3-bit mode select behaviour
// - status shows flags, count; routable to pin
// - bypass stores nothing, buffer stays empty
// - fill mode stops accepting when full
// - stop bit limits depth to watermark
// - stream mode overwrites oldest when full
// - stream until trigger, then fill mode
// - bypass until trigger, then stream
// - bypass until trigger, then fill
// - averaging mode, window set by watermark
// - averaged output optionally decimated per rate
// - averaging mode hides individual entries
// - each sample read presents oldest entry
// - burst pointer wraps 2Ah back to 28h while the buffer is enabled
// - data-ready flag on every new sample
`timescale 1ns/1ps
`default_nettype none
module psf_sample_fifo (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sample_valid_i,
  input wire logic [23:0] sample_i,
  input wire logic interrupt_active_i,
  input wire logic [2:0] output_rate_i,
  input wire logic reg_sub_load_i,
  input wire logic [7:0] reg_sub_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic ready_interrupt_pin_o,
  output logic [7:0] trigger_cfg_o
);
  logic [23:0] mem [psf_pkg::DEPTH];
  logic [7:0] ctrl2_q;
  logic [7:0] route_q;
  logic [7:0] trig_cfg_q;
  logic [7:0] qctl_q;
  logic [6:0] ptr_q;
  logic inc_q;
  logic [4:0] rd_q;
  logic [4:0] wr_q;
  logic [5:0] count_q;
  logic [5:0] count_d;
  logic signed [28:0] sum_q;
  logic [23:0] out_q;
  logic trig_q;
  logic drdy_q;
  logic ovr_q;
  logic wtm_q;
  logic pin_q;
  logic [7:0] rdata_q;

  logic fifo_en;
  logic stop_wm;
  logic dec_en;
  logic [2:0] mode;
  logic [4:0] wm;
  logic [2:0] shift;
  logic [5:0] limit;
  logic full;
  logic mean;
  psf_pkg::psf_bhv_t bhv;
  logic access;
  logic rd_acc;
  logic wr_acc;
  logic mode_wr;
  logic flush;
  logic push;
  logic drop;
  logic pop;
  logic [23:0] avg;
  logic mean_tick;
  logic signed [28:0] add_term;
  logic signed [28:0] sub_term;

  function automatic logic [2:0] win_shift(input logic [4:0] w);
    case (w)
      5'h01: win_shift = 3'h1;
      5'h03: win_shift = 3'h2;
      5'h07: win_shift = 3'h3;
      5'h0f: win_shift = 3'h4;
      5'h1f: win_shift = 3'h5;
      default: win_shift = 3'h1;
    endcase
  endfunction

  function automatic logic [6:0] next_ptr(input logic [6:0] p, input logic en);
    if (en && p == psf_pkg::ADDR_PHI) begin
      next_ptr = psf_pkg::ADDR_PLO;
    end else begin
      next_ptr = p + 7'h01;
    end
  endfunction

  assign fifo_en = ctrl2_q[psf_pkg::CTRL2_EN_BIT];
  assign stop_wm = ctrl2_q[psf_pkg::CTRL2_STOP_BIT];
  assign dec_en = ctrl2_q[psf_pkg::CTRL2_DEC_BIT];
  assign mode = qctl_q[7:psf_pkg::QCTL_MODE_LSB];
  assign wm = qctl_q[4:0];
  assign shift = win_shift(wm);

  assign access = (reg_rd_i || reg_wr_i) && !reg_sub_load_i;
  assign rd_acc = reg_rd_i && !reg_sub_load_i;
  assign wr_acc = reg_wr_i && !reg_sub_load_i;
  assign mode_wr = wr_acc && ptr_q == psf_pkg::ADDR_QCTL;

  // register pointer, loaded from the sub-address
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ptr_q <= 7'h00;
      inc_q <= 1'b0;
    end else if (reg_sub_load_i) begin
      ptr_q <= reg_sub_i[6:0];
      inc_q <= reg_sub_i[psf_pkg::SUB_INC_BIT];
    end else if (access && inc_q) begin
      ptr_q <= next_ptr(ptr_q, fifo_en);
    end
  end

  // writable registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl2_q <= psf_pkg::REG_RST;
      route_q <= psf_pkg::REG_RST;
      trig_cfg_q <= psf_pkg::REG_RST;
      qctl_q <= psf_pkg::REG_RST;
    end else if (wr_acc) begin
      case (ptr_q)
        psf_pkg::ADDR_CTRL2: ctrl2_q <= reg_wdata_i;
        psf_pkg::ADDR_ROUTE: route_q <= reg_wdata_i;
        psf_pkg::ADDR_TRIG: trig_cfg_q <= reg_wdata_i;
        psf_pkg::ADDR_QCTL: qctl_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  assign trigger_cfg_o = trig_cfg_q;

  // trigger seen since the mode was written or the buffer enabled
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_q <= 1'b0;
    end else if (!fifo_en || mode_wr) begin
      trig_q <= 1'b0;
    end else if (interrupt_active_i) begin
      trig_q <= 1'b1;
    end
  end

  // effective behaviour of the buffer
  always_comb begin
    bhv = psf_pkg::PSF_BHV_BYPASS;
    mean = 1'b0;
    if (fifo_en) begin
      case (mode)
        psf_pkg::MODE_BYPASS: bhv = psf_pkg::PSF_BHV_BYPASS;
        psf_pkg::MODE_FIFO: bhv = psf_pkg::PSF_BHV_FILL;
        psf_pkg::MODE_STREAM: bhv = psf_pkg::PSF_BHV_STREAM;
        psf_pkg::MODE_S2F: begin
          bhv = trig_q ? psf_pkg::PSF_BHV_FILL : psf_pkg::PSF_BHV_STREAM;
        end
        psf_pkg::MODE_B2S: begin
          bhv = trig_q ? psf_pkg::PSF_BHV_STREAM : psf_pkg::PSF_BHV_BYPASS;
        end
        psf_pkg::MODE_B2F: begin
          bhv = trig_q ? psf_pkg::PSF_BHV_FILL : psf_pkg::PSF_BHV_BYPASS;
        end
        psf_pkg::MODE_MEAN: begin
          bhv = psf_pkg::PSF_BHV_STREAM;
          mean = 1'b1;
        end
        default: bhv = psf_pkg::PSF_BHV_BYPASS;
      endcase
    end
  end

  // usable depth
  always_comb begin
    if (mean) begin
      limit = 6'h01 << shift;
    end else if (stop_wm && wm != 5'h00) begin
      limit = {1'b0, wm};
    end else begin
      limit = psf_pkg::DEPTH_CNT;
    end
  end

  assign full = count_q >= limit;
  assign flush = bhv == psf_pkg::PSF_BHV_BYPASS || mode_wr;
  // a pop in the same cycle frees the slot, so nothing is lost
  assign push = sample_valid_i && !flush
    && (!full || pop || bhv == psf_pkg::PSF_BHV_STREAM);
  assign drop = push && full && !pop;
  assign pop = rd_acc && ptr_q == psf_pkg::ADDR_PHI && !mean && count_q != 6'h00;

  always_comb begin
    count_d = count_q;
    if (push && !drop) begin
      count_d = count_d + 6'h01;
    end
    if (pop) begin
      count_d = count_d - 6'h01;
    end
  end

  // storage and pointers
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= sample_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_q <= 5'h00;
      rd_q <= 5'h00;
      count_q <= 6'h00;
    end else if (flush) begin
      rd_q <= wr_q;
      count_q <= 6'h00;
    end else begin
      if (push) begin
        wr_q <= wr_q + 5'h01;
      end
      rd_q <= rd_q + 5'(drop) + 5'(pop);
      count_q <= count_d;
    end
  end

  // running sum for the moving average
  assign add_term = {{5{sample_i[23]}}, sample_i};
  assign sub_term = drop ? {{5{mem[rd_q][23]}}, mem[rd_q]} : 29'sh0000000;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sum_q <= 29'sh0000000;
    end else if (flush || !mean) begin
      sum_q <= 29'sh0000000;
    end else if (push) begin
      sum_q <= sum_q + add_term - sub_term;
    end
  end

  psf_decim u_decim (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .sample_i(push && mean),
    .dec_en_i(dec_en),
    .rate_i(output_rate_i),
    .tick_o(mean_tick)
  );

  psf_mean u_mean (
    .sum_i(sum_q),
    .shift_i(shift),
    .avg_o(avg)
  );

  // output word: live sample, average, or oldest stored entry
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_q <= psf_pkg::OUT_RST;
    end else if (bhv == psf_pkg::PSF_BHV_BYPASS) begin
      if (sample_valid_i) begin
        out_q <= sample_i;
      end
    end else if (mean) begin
      if (mean_tick) begin
        out_q <= avg;
      end
    end else if (count_q != 6'h00) begin
      out_q <= mem[rd_q];
    end
  end

  // event flags; a set in the same cycle beats the clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drdy_q <= 1'b0;
    end else if (sample_valid_i) begin
      drdy_q <= 1'b1;
    end else if (rd_acc && ptr_q == psf_pkg::ADDR_PHI) begin
      drdy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovr_q <= 1'b0;
    end else if (sample_valid_i && !flush && full) begin
      ovr_q <= 1'b1;
    end else if (rd_acc && ptr_q == psf_pkg::ADDR_QSTAT) begin
      ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wtm_q <= 1'b0;
    end else begin
      wtm_q <= wm != 5'h00 && count_q >= {1'b0, wm};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= (route_q[psf_pkg::ROUTE_DRDY_BIT] && drdy_q)
        || (route_q[psf_pkg::ROUTE_OVR_BIT] && ovr_q)
        || (route_q[psf_pkg::ROUTE_WTM_BIT] && wtm_q);
    end
  end

  assign ready_interrupt_pin_o = pin_q;

  // read data, one cycle after the access
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= psf_pkg::REG_RST;
    end else if (rd_acc) begin
      case (ptr_q)
        psf_pkg::ADDR_CTRL2: rdata_q <= ctrl2_q;
        psf_pkg::ADDR_ROUTE: rdata_q <= route_q;
        psf_pkg::ADDR_TRIG: rdata_q <= trig_cfg_q;
        psf_pkg::ADDR_SRC: begin
          rdata_q <= 8'(interrupt_active_i) << psf_pkg::SRC_IA_BIT;
        end
        psf_pkg::ADDR_PLO: rdata_q <= out_q[7:0];
        psf_pkg::ADDR_PMID: rdata_q <= out_q[15:8];
        psf_pkg::ADDR_PHI: rdata_q <= out_q[23:16];
        psf_pkg::ADDR_QCTL: rdata_q <= qctl_q;
        psf_pkg::ADDR_QSTAT: rdata_q <= {wtm_q, ovr_q, count_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_o = rdata_q;

  AST_DISABLED_BYPASS: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !fifo_en |-> ##1 count_q == 6'h00)
    else $error("buffer holds data while disabled");

  AST_BYPASS_EMPTY: assert property (@(posedge clk_i) disable iff (!rstn_i)
    fifo_en && mode == psf_pkg::MODE_BYPASS && sample_valid_i |=> count_q == 6'h00)
    else $error("bypass mode stored a sample");

  AST_COUNT_MAX: assert property (@(posedge clk_i) disable iff (!rstn_i)
    count_q <= psf_pkg::DEPTH_CNT)
    else $error("count above buffer depth");

  AST_FILL_STOP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bhv == psf_pkg::PSF_BHV_FILL && full && sample_valid_i && !pop && !mode_wr
    |=> count_q == $past(count_q) && wr_q == $past(wr_q))
    else $error("fill mode accepted a sample while full");

  AST_STREAM_DROP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bhv == psf_pkg::PSF_BHV_STREAM && full && sample_valid_i && !pop && !mode_wr
    |=> rd_q == $past(rd_q) + 5'h01 && count_q == $past(count_q))
    else $error("stream mode did not drop oldest entry");

  AST_OVERRUN: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sample_valid_i && !flush && full |=> ovr_q)
    else $error("overrun flag not set");

  AST_WATERMARK: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wm != 5'h00 && count_q < {1'b0, wm} |=> !wtm_q)
    else $error("threshold flag set below watermark");

  AST_BURST_WRAP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    access && inc_q && fifo_en && ptr_q == psf_pkg::ADDR_PHI |=> ptr_q == psf_pkg::ADDR_PLO)
    else $error("burst pointer did not wrap");

  AST_DRDY: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sample_valid_i |=> drdy_q)
    else $error("data ready not raised on sample");

  AST_MEAN_NO_POP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mean && rd_acc && ptr_q == psf_pkg::ADDR_PHI && !sample_valid_i && !mode_wr
    |=> count_q == $past(count_q))
    else $error("averaging mode popped an entry");

  AST_EMPTY_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !mean && bhv != psf_pkg::PSF_BHV_BYPASS && count_q == 6'h00 && !push
    |=> out_q == $past(out_q))
    else $error("output changed while buffer empty");
endmodule
`default_nettype wire

// >>> pkg/psf_pkg.sv
`default_nettype none
package psf_pkg;
  // sample and buffer shape
  localparam int unsigned DATA_W = 24;
  localparam int unsigned DEPTH = 32;
  localparam int unsigned PTR_W = 5;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned SUM_W = 29;
  // output word scaling: value / 4096 gives hPa
  localparam int unsigned PRESS_LSB_PER_HPA = 4096;
  localparam logic [5:0] DEPTH_CNT = 6'h20;

  // register map (7-bit register address)
  localparam logic [6:0] ADDR_CTRL2 = 7'h21;
  localparam logic [6:0] ADDR_ROUTE = 7'h23;
  localparam logic [6:0] ADDR_TRIG = 7'h24;
  localparam logic [6:0] ADDR_SRC = 7'h25;
  localparam logic [6:0] ADDR_PLO = 7'h28;
  localparam logic [6:0] ADDR_PMID = 7'h29;
  localparam logic [6:0] ADDR_PHI = 7'h2a;
  localparam logic [6:0] ADDR_QCTL = 7'h2e;
  localparam logic [6:0] ADDR_QSTAT = 7'h2f;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [23:0] OUT_RST = 24'h000000;

  // field positions
  localparam int unsigned CTRL2_EN_BIT = 6;
  localparam int unsigned CTRL2_STOP_BIT = 5;
  localparam int unsigned CTRL2_DEC_BIT = 4;
  localparam int unsigned ROUTE_DRDY_BIT = 0;
  localparam int unsigned ROUTE_OVR_BIT = 1;
  localparam int unsigned ROUTE_WTM_BIT = 2;
  localparam int unsigned SRC_IA_BIT = 2;
  localparam int unsigned QSTAT_WTM_BIT = 7;
  localparam int unsigned QSTAT_OVR_BIT = 6;
  localparam int unsigned QCTL_MODE_LSB = 5;
  localparam int unsigned SUB_INC_BIT = 7;

  // mode field codes
  localparam logic [2:0] MODE_BYPASS = 3'h0;
  localparam logic [2:0] MODE_FIFO = 3'h1;
  localparam logic [2:0] MODE_STREAM = 3'h2;
  localparam logic [2:0] MODE_S2F = 3'h3;
  localparam logic [2:0] MODE_B2S = 3'h4;
  localparam logic [2:0] MODE_MEAN = 3'h6;
  localparam logic [2:0] MODE_B2F = 3'h7;

  // decimation in averaging mode, counted in samples per output
  localparam logic [2:0] RATE_7HZ = 3'h2;
  localparam logic [2:0] RATE_12HZ5 = 3'h3;
  localparam logic [2:0] RATE_25HZ = 3'h4;
  localparam logic [4:0] DEC_N_7HZ = 5'h07;
  localparam logic [4:0] DEC_N_12HZ5 = 5'h0c;
  localparam logic [4:0] DEC_N_25HZ = 5'h19;

  typedef enum logic [2:0] {
    PSF_BHV_BYPASS = 3'b001,
    PSF_BHV_FILL = 3'b010,
    PSF_BHV_STREAM = 3'b100
  } psf_bhv_t;
endpackage
`default_nettype wire

// >>> rtl/psf_decim.sv
`timescale 1ns/1ps
`default_nettype none
module psf_decim (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sample_i,
  input wire logic dec_en_i,
  input wire logic [2:0] rate_i,
  output logic tick_o
);
  logic [4:0] cnt_q;
  logic [4:0] n;

  always_comb begin
    case (rate_i)
      psf_pkg::RATE_7HZ: n = psf_pkg::DEC_N_7HZ;
      psf_pkg::RATE_12HZ5: n = psf_pkg::DEC_N_12HZ5;
      psf_pkg::RATE_25HZ: n = psf_pkg::DEC_N_25HZ;
      default: n = 5'h01;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 5'h00;
      tick_o <= 1'b0;
    end else if (!dec_en_i) begin
      cnt_q <= 5'h00;
      tick_o <= sample_i;
    end else if (sample_i) begin
      if (cnt_q >= n - 5'h01) begin
        cnt_q <= 5'h00;
        tick_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 5'h01;
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/psf_mean.sv
`timescale 1ns/1ps
`default_nettype none
module psf_mean (
  input wire logic signed [28:0] sum_i,
  input wire logic [2:0] shift_i,
  output logic [23:0] avg_o
);
  logic signed [28:0] q;

  // arithmetic shift keeps the sign of the two's complement sum
  always_comb begin
    q = sum_i >>> shift_i;
    avg_o = q[23:0];
  end
endmodule
`default_nettype wire

// >>> bench/psf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module psf_host_model #(
  parameter logic [7:0] LATCH_INT = 8'h04
) (
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_sub_load_o,
  output logic [7:0] reg_sub_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_sub_load_o = 1'b0;
    reg_sub_o = 8'h00;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // msb of the sub-address asks for auto increment
  task automatic point(input logic [6:0] addr, input logic inc);
    @(negedge clk_i);
    reg_sub_load_o = 1'b1;
    reg_sub_o = {inc, addr};
    @(negedge clk_i);
    reg_sub_load_o = 1'b0;
    reg_sub_o = ~reg_sub_o;
  endtask
  // released data lines show the inverse of the last value
  task automatic wr(input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_o = 1'b1;
    reg_wdata_o = d;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
  // two-cycle spacing keeps output-word reads legal
  task automatic rd(output logic [7:0] d);
    @(negedge clk_i);
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask
  task automatic latch_cfg();
    point(psf_pkg::ADDR_TRIG, 1'b0);
    wr(LATCH_INT);
  endtask
endmodule
`default_nettype wire

// >>> bench/pressure_sample_fifo_test.sv
`timescale 1ns/1ps
`default_nettype none
module pressure_sample_fifo_test;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic [23:0] sample_i = 24'h000000;
  logic interrupt_active_i = 1'b0;
  logic [2:0] output_rate_i = 3'h2;
  logic sub_load, rd, wr, pin;
  logic [7:0] sub, wdata, rdata, trig;
  int mismatches = 0;
  int cmp_count = 0;
  always #50 clk_i = ~clk_i;
  psf_host_model host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_sub_load_o(sub_load),
    .reg_sub_o(sub), .reg_rd_o(rd), .reg_wr_o(wr), .reg_wdata_o(wdata));
  psf_sample_fifo dut (.clk_i(clk_i), .rstn_i(rstn_i), .sample_valid_i(sample_valid_i),
    .sample_i(sample_i), .interrupt_active_i(interrupt_active_i),
    .output_rate_i(output_rate_i), .reg_sub_load_i(sub_load), .reg_sub_i(sub),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .ready_interrupt_pin_o(pin), .trigger_cfg_o(trig));
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [23:0] val(input int i);
    return {i[7:0], ~i[7:0], 8'h5a};
  endfunction
  task automatic setreg(input logic [6:0] a, input logic [7:0] d);
    host.point(a, 1'b0);
    host.wr(d);
  endtask
  task automatic getreg(input logic [6:0] a, output logic [7:0] d);
    host.point(a, 1'b0);
    host.rd(d);
  endtask
  task automatic stat(input logic [7:0] exp, input logic [7:0] mask);
    logic [7:0] d;
    getreg(psf_pkg::ADDR_QSTAT, d);
    check("status", {16'h0000, d & mask}, {16'h0000, exp});
  endtask
  task automatic mode(input logic [2:0] m, input logic [4:0] wm);
    setreg(psf_pkg::ADDR_QCTL, {m, wm});
  endtask
  task automatic push(input logic [23:0] v);
    @(negedge clk_i);
    sample_valid_i = 1'b1;
    sample_i = v;
    @(negedge clk_i);
    sample_valid_i = 1'b0;
    sample_i = ~v;
  endtask
  task automatic rword(output logic [23:0] w);
    logic [7:0] b0, b1, b2;
    host.rd(b0);
    host.rd(b1);
    host.rd(b2);
    w = {b2, b1, b0};
  endtask
  task automatic t_regs();
    logic [7:0] d;
    getreg(psf_pkg::ADDR_CTRL2, d);
    check("ctrl reset", {16'h0, d}, {16'h0, psf_pkg::REG_RST});
    getreg(7'h22, d);
    check("unmapped", {16'h0, d}, 24'h0);
    setreg(psf_pkg::ADDR_QSTAT, 8'hff);
    stat(8'h00, 8'hff);
    host.latch_cfg();
    check("trigger cfg", {16'h0, trig}, {16'h0, host.LATCH_INT});
    host.point(psf_pkg::ADDR_CTRL2, 1'b1);
    host.wr(8'h40);
    host.wr(8'h00);
    host.wr(8'h01);
    getreg(psf_pkg::ADDR_ROUTE, d);
    check("routing", {16'h0, d}, 24'h1);
  endtask
  task automatic t_bypass();
    logic [23:0] w;
    mode(psf_pkg::MODE_BYPASS, 5'h00);
    push(24'hfedcba);
    @(negedge clk_i);
    check("ready pin", {23'h0, pin}, 24'h1);
    stat(8'h00, 8'hff);
    host.point(psf_pkg::ADDR_PLO, 1'b1);
    rword(w);
    check("bypass word", w, 24'hfedcba);
    @(negedge clk_i);
    check("ready cleared", {23'h0, pin}, 24'h0);
  endtask
  task automatic t_fifo();
    logic [23:0] w;
    mode(psf_pkg::MODE_FIFO, 5'h00);
    for (int i = 0; i < 33; i++) push(val(i));
    stat(8'h60, 8'hff);
    host.point(psf_pkg::ADDR_PLO, 1'b1);
    for (int i = 0; i < 32; i++) begin
      rword(w);
      check("burst entry", w, val(i));
    end
    rword(w);
    check("empty read", w, val(31));
    stat(8'h00, 8'hff);
  endtask
  task automatic t_stream();
    logic [23:0] w;
    mode(psf_pkg::MODE_STREAM, 5'h00);
    for (int i = 0; i < 34; i++) push(val(i));
    stat(8'h60, 8'hff);
    host.point(psf_pkg::ADDR_PLO, 1'b1);
    rword(w);
    check("stream oldest", w, val(2));
  endtask
  task automatic t_wtm();
    logic [23:0] w;
    setreg(psf_pkg::ADDR_CTRL2, 8'h60);
    setreg(psf_pkg::ADDR_ROUTE, 8'h04);
    mode(psf_pkg::MODE_FIFO, 5'h04);
    for (int i = 0; i < 5; i++) push(val(i));
    stat(8'h84, 8'hbf);
    check("wtm pin", {23'h0, pin}, 24'h1);
    host.point(psf_pkg::ADDR_PLO, 1'b1);
    rword(w);
    stat(8'h03, 8'hbf);
    check("wtm pin low", {23'h0, pin}, 24'h0);
    setreg(psf_pkg::ADDR_CTRL2, 8'h40);
    setreg(psf_pkg::ADDR_ROUTE, 8'h01);
  endtask
  // pre-trigger samples, trigger, then 34 more
  task automatic t_trig(input logic [2:0] m, input int pre, input logic [7:0] pre_st,
                        input int first);
    logic [23:0] w;
    logic [7:0] d;
    mode(m, 5'h00);
    for (int i = 0; i < pre; i++) push(val(i));
    stat(pre_st, 8'hff);
    @(negedge clk_i);
    interrupt_active_i = 1'b1;
    getreg(psf_pkg::ADDR_SRC, d);
    check("event source", {16'h0, d}, 24'h000004);
    for (int i = pre; i < pre + 34; i++) push(val(i));
    interrupt_active_i = 1'b0;
    stat(8'h60, 8'hff);
    host.point(psf_pkg::ADDR_PLO, 1'b1);
    rword(w);
    check("post trigger oldest", w, val(first));
  endtask
  task automatic t_mean();
    logic [23:0] w;
    int n;
    for (int k = 1; k <= 5; k++) begin
      n = 1 << k;
      mode(psf_pkg::MODE_MEAN, 5'((1 << k) - 1));
      for (int i = 1; i <= 2 * n; i++) push(24'(16 * i));
      host.point(psf_pkg::ADDR_PLO, 1'b1);
      rword(w);
      check("average", w, 24'(8 * (3 * n + 1)));
      rword(w);
      check("average held", w, 24'(8 * (3 * n + 1)));
    end
    // decimated: output moves only on the last sample of each group
    setreg(psf_pkg::ADDR_CTRL2, 8'h50);
    mode(psf_pkg::MODE_MEAN, 5'h01);
    for (int i = 1; i < int'(psf_pkg::DEC_N_7HZ); i++) push(24'(16 * i));
    host.point(psf_pkg::ADDR_PLO, 1'b1);
    rword(w);
    check("decimated held", w, 24'(8 * (3 * 32 + 1)));
    push(24'(16 * int'(psf_pkg::DEC_N_7HZ)));
    rword(w);
    check("decimated average", w, 24'(8 * (2 * int'(psf_pkg::DEC_N_7HZ) - 1)));
    setreg(psf_pkg::ADDR_CTRL2, 8'h40);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rstn_i = 1'b1;
    t_regs();
    t_bypass();
    t_fifo();
    t_stream();
    t_wtm();
    t_trig(psf_pkg::MODE_S2F, 34, 8'h60, 2);
    t_trig(psf_pkg::MODE_B2S, 3, 8'h00, 5);
    t_trig(psf_pkg::MODE_B2F, 3, 8'h00, 3);
    t_mean();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
